// ### hdl/two_wire_shift_serial_unit.sv
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "serial_shift_map.svh"
// Operation
// R1 - Two-wire bus protocol, no slew or filtering
// R2 - Master clocks; slave uses hold; hardware shifts
// R3 - Software picks negative edge for two-wire
// R4 - Slave may stretch; master checks SCL release
// R5 - Each shift clock also increments counter
// R6 - Master toggles clock pin through port
// R7 - Higher protocol decides data direction
// R8 - SDA delayed for start detect, two-wire only
// R9 - Start detector needs no shift clock
// R10 - Serial clock at most quarter system clock
// R11 - Slave holds SCL low until ready
// R12 - External clock counts both edges
// R13 - Counter chains with companion timer
// R14 - Preload F gives external edge interrupt
// R15 - Software strobe overflow raises interrupt
// R16 - Data register is the shift register
// R17 - Write wins over simultaneous shift clock
// R18 - Left shift from selected clock source
// R19 - No wire mode still uses pins
// R20 - Output pin follows bit 7 via latch
// R21 - Latch open opposite the sampling edge
module two_wire_shift_serial_unit #(
  parameter int DW = 8,
  parameter int CW = 4
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        shift_clock_pin_in,
  output logic             shift_clock_pin_out,
  output logic             shift_clock_pin_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        serial_in_pin,
  output logic             data_out_pin,
  input  wire logic        timer_match,
  output logic             counter_ovf_to_timer,
  output logic             start_irq,
  output logic             ovf_irq
);

  localparam int DLY = `SDA_DLY_CYC;

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers: scl, sda, serial_in
  logic [2:0]   pin_raw;
  logic [2:0]   sync1_ff;
  logic [2:0]   sync2_ff;
  logic [2:0]   prev_ff;
  logic [DLY:0] sda_dly_ff;

  assign pin_raw = {serial_in_pin, sda_in, shift_clock_pin_in};

  // Two flops per pin, third flop for edge finding
  generate
    for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          sync1_ff[i] <= 1'b1;
          sync2_ff[i] <= 1'b1;
          prev_ff[i]  <= 1'b1;
        end else begin
          sync1_ff[i] <= pin_raw[i];
          sync2_ff[i] <= sync1_ff[i];
          prev_ff[i]  <= sync2_ff[i];
        end
      end
    end
  endgenerate

  // SDA delay line for start detection
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_dly_ff <= '1;
    end else begin
      sda_dly_ff <= {sda_dly_ff[DLY-1:0], sync2_ff[1]}; // R8
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registers
  serial_shift_pkg::ctrl_s ctrl_ff;
  logic [DW-1:0] data_ff;
  logic [CW-1:0] cnt_ff;
  logic          start_flag_ff;
  logic          ovf_flag_ff;
  logic          latch_ff;
  logic          pready_ff;
  logic          pslverr_ff;
  logic [31:0]   prdata_ff;
  logic          scl_oe_ff;
  logic          sda_oe_ff;
  logic          dout_ff;
  logic          cnt_ovf_ff;
  logic          start_irq_ff;
  logic          ovf_irq_ff;

  // Bus decode
  wire acc      = psel & penable;
  wire wr_done  = acc & pwrite & pready_ff;
  wire hit_data = paddr == `OFS_DATA;
  wire hit_stat = paddr == `OFS_STATUS;
  wire hit_ctrl = paddr == `OFS_CTRL;
  wire mapped   = hit_data | hit_stat | hit_ctrl;
  wire wr_data  = wr_done & hit_data;
  wire wr_stat  = wr_done & hit_stat;
  wire wr_ctrl  = wr_done & hit_ctrl;
  wire strobe   = wr_ctrl & pwdata[`CT_STROBE];

  // Mode decode
  wire two_wire = ctrl_ff.wire_mode_sel[1];
  wire ext_src  = ctrl_ff.shift_clock_source_sel[1]; // R14
  wire neg_sel  = ctrl_ff.shift_clock_source_sel[0];

  // Clock pin edges, R10 keeps them two or more cycles apart
  wire clk_s    = sync2_ff[0];
  wire clk_rise = clk_s & ~prev_ff[0]; // R10
  wire clk_fall = ~clk_s & prev_ff[0];
  wire ext_edge = neg_sel ? clk_fall : clk_rise;

  // Shift and count events
  wire shift_ev = ext_src ? ext_edge
                : (neg_sel ? timer_match : strobe); // R18
  wire count_ev = ext_src ? (clk_rise | clk_fall) : shift_ev; // R5 R12 R15
  wire cnt_wrap = count_ev & (cnt_ff == {CW{1'b1}}) & ~wr_stat; // R14

  // Data input pin: SDA in two-wire, serial_in otherwise
  wire din      = two_wire ? sync2_ff[1] : sync2_ff[2]; // R19

  // Start condition: delayed SDA falls while SCL high
  wire start_ev = two_wire & clk_s & sda_dly_ff[DLY] & ~sda_dly_ff[DLY-1]; // R8 R9

  // Latch transparent opposite the sampling edge
  wire latch_open = neg_sel ? clk_s : ~clk_s; // R21

  // Clock hold for slave
  wire nxt_hold = two_wire & (start_flag_ff | (ctrl_ff.wire_mode_sel
                  == serial_shift_pkg::WM_HOLD & ovf_flag_ff)); // R11 R2 R4

  // Read mux
  wire [31:0] rd_mux = hit_data ? {24'h0, data_ff}
                     : hit_stat ? {24'h0, start_flag_ff, ovf_flag_ff, 2'h0, cnt_ff}
                     : hit_ctrl ? {24'h0, ctrl_ff, 2'h0}
                     : 32'h0;

  ////////////////////////////////////////////////////////////////////
  // APB answer: one wait state, read data registered
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end else begin
      pready_ff  <= acc & ~pready_ff;
      pslverr_ff <= acc & ~pready_ff & ~mapped;
      prdata_ff  <= (acc & ~pready_ff & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  // Control register, strobe bit is not stored
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= '0;
    end else if (wr_ctrl) begin
      ctrl_ff <= pwdata[`CT_START_IE:`CT_CS_LO];
    end
  end

  // Shift register: write beats shift
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_ff <= `RST_DATA;
    end else if (wr_data) begin
      data_ff <= pwdata[DW-1:0]; // R16 R17
    end else if (shift_ev) begin
      data_ff <= {data_ff[DW-2:0], din}; // R18 R2
    end
  end

  // Counter: write beats count
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= `RST_CNT;
    end else if (wr_stat) begin
      cnt_ff <= pwdata[CW-1:0];
    end else if (count_ev) begin
      cnt_ff <= cnt_ff + 1'b1; // R5 R12
    end
  end

  // Sticky flags, start set wins over clear; a status write masks the overflow set
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_flag_ff <= 1'b0;
      ovf_flag_ff   <= 1'b0;
    end else begin
      start_flag_ff <= start_ev | (start_flag_ff & ~(wr_stat & pwdata[`ST_START_BIT]));
      ovf_flag_ff   <= cnt_wrap | (ovf_flag_ff & ~(wr_stat & pwdata[`ST_OVF_BIT])); // R14 R15
    end
  end

  // Output latch from bit 7
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_ff <= 1'b1;
    end else if (latch_open) begin
      latch_ff <= data_ff[DW-1]; // R20 R21
    end
  end

  // Pin and event outputs
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_oe_ff    <= 1'b0;
      sda_oe_ff    <= 1'b0;
      dout_ff      <= 1'b0;
      cnt_ovf_ff   <= 1'b0;
      start_irq_ff <= 1'b0;
      ovf_irq_ff   <= 1'b0;
    end else begin
      scl_oe_ff    <= nxt_hold; // R11
      sda_oe_ff    <= two_wire & ~latch_ff; // R1 R20
      dout_ff      <= (ctrl_ff.wire_mode_sel == serial_shift_pkg::WM_THREE) & latch_ff;
      cnt_ovf_ff   <= cnt_wrap; // R13
      start_irq_ff <= start_flag_ff & ctrl_ff.start_ie;
      ovf_irq_ff   <= ovf_flag_ff & ctrl_ff.ovf_ie; // R15
    end
  end

  assign prdata               = prdata_ff;
  assign pready               = pready_ff;
  assign pslverr              = pslverr_ff;
  assign shift_clock_pin_out  = 1'b0;
  assign shift_clock_pin_oe   = scl_oe_ff;
  assign sda_out              = 1'b0;
  assign sda_oe               = sda_oe_ff;
  assign data_out_pin         = dout_ff;
  assign counter_ovf_to_timer = cnt_ovf_ff;
  assign start_irq            = start_irq_ff;
  assign ovf_irq              = ovf_irq_ff;

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_wrap;
    count_ev & (cnt_ff == 4'hf) & ~wr_stat;
  endsequence

  sequence s_flag_up;
    ##1 ovf_flag_ff ##1 (ovf_irq_ff == ctrl_ff.ovf_ie);
  endsequence

  a_ovf_flag_set: assert property (s_wrap |-> s_flag_up) // R14
    else $error("overflow did not set flag");
  a_count_step: assert property (count_ev & ~wr_stat |=> cnt_ff == $past(cnt_ff) + 4'h1) // R5
    else $error("counter did not step");
  a_both_edges: assert property (ext_src & clk_fall & ~wr_stat
                                 |=> cnt_ff != $past(cnt_ff)) // R12
    else $error("falling edge not counted");
  a_write_wins: assert property (wr_data |=> data_ff == $past(pwdata[7:0])) // R17
    else $error("write lost to shift");
  a_left_shift: assert property (shift_ev & ~wr_data
                                 |=> data_ff == {$past(data_ff[6:0]), $past(din)}) // R18
    else $error("shift wrong");
  a_strobe_shift: assert property (strobe & ~ext_src & ~neg_sel
                                   |=> data_ff[0] == $past(din)) // R15
    else $error("strobe did not shift");
  a_start_mode: assert property (~two_wire |=> ~start_flag_ff | $past(start_flag_ff)) // R8
    else $error("start seen outside two-wire");
  a_scl_hold: assert property (two_wire & start_flag_ff |=> shift_clock_pin_oe) // R11
    else $error("scl not held");
  a_chain_pulse: assert property (s_wrap |=> counter_ovf_to_timer ##1 ~counter_ovf_to_timer
                                  or s_wrap) // R13
    else $error("chain pulse wrong");
  a_latch_hold: assert property (~latch_open |=> latch_ff == $past(latch_ff)) // R21
    else $error("latch moved on sampling phase");
  a_sda_bit7: assert property (two_wire & latch_open ##1 two_wire
                               |=> sda_oe == ~$past(data_ff[7], 2)) // R20
    else $error("sda not bit 7");
  a_data_read: assert property (acc & ~pready_ff & ~pwrite & hit_data
                                |=> prdata == {24'h0, $past(data_ff)}) // R16
    else $error("read not shift register");

endmodule : two_wire_shift_serial_unit

// ### hdl/serial_shift_map.svh
`ifndef SERIAL_SHIFT_MAP_SVH
`define SERIAL_SHIFT_MAP_SVH
// Register byte offsets
`define OFS_DATA     8'h00
`define OFS_STATUS   8'h04
`define OFS_CTRL     8'h08
// Status fields
`define ST_START_BIT 7
`define ST_OVF_BIT   6
// Control fields
`define CT_START_IE  7
`define CT_OVF_IE    6
`define CT_WM_HI     5
`define CT_WM_LO     4
`define CT_CS_HI     3
`define CT_CS_LO     2
`define CT_STROBE    0
// Reset values
`define RST_DATA     8'h00
`define RST_CNT      4'h0
// Timing
`define CLK_NS       40
`define SDA_DLY_NS   50
`define SDA_DLY_CYC  ((`SDA_DLY_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ### hdl/serial_shift_pkg.sv
package serial_shift_pkg;
  // Wire mode field
  typedef enum logic [1:0] {
    WM_NONE  = 2'h0,
    WM_THREE = 2'h1,
    WM_TWO   = 2'h2,
    WM_HOLD  = 2'h3
  } wire_mode_e;

  // Shift clock source field
  typedef enum logic [1:0] {
    CS_SOFT  = 2'h0,
    CS_TIMER = 2'h1,
    CS_EXTP  = 2'h2,
    CS_EXTN  = 2'h3
  } clk_src_e;

  // Control register contents
  typedef struct packed {
    logic       start_ie;
    logic       ovf_ie;
    wire_mode_e wire_mode_sel;
    clk_src_e   shift_clock_source_sel;
  } ctrl_s;
endpackage : serial_shift_pkg

// ### verif/serial_bus_partner.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Far-side master: shift clock, data in, SDA start and stop
module serial_bus_partner (
  input  wire logic core_clk,
  input  wire logic scl_line,
  input  wire logic dout,
  output logic      sck,
  output logic      din,
  output logic      sda
);
  // Idle bus levels
  initial begin
    sck = 1'b1;
    din = 1'b1;
    sda = 1'b1;
  end

  // One clock level, four core cycles, wait for release
  task automatic edge_to(input logic lvl);
    sck <= lvl;
    repeat (4) @(posedge core_clk);
    while (lvl && !scl_line) @(posedge core_clk);
  endtask : edge_to

  // SDA level change with clock standing still
  task automatic sda_to(input logic lvl);
    sda <= lvl;
    repeat (8) @(posedge core_clk);
  endtask : sda_to

  // Byte out MSB first; reply sampled in each high phase
  task automatic send_byte(input logic [7:0] tx, output logic [7:0] rx);
    din <= tx[7];
    repeat (4) @(posedge core_clk);
    for (int k = 7; k >= 0; k--) begin
      edge_to(1'b0);
      sck <= 1'b1;
      repeat (2) @(posedge core_clk);
      rx[k] = dout;
      din <= (k > 0) ? tx[(k+7)%8] : ~tx[0]; // No stale bit after frame
      repeat (2) @(posedge core_clk);
    end
  endtask : send_byte
endmodule : serial_bus_partner

// ### verif/two_wire_shift_serial_unit_tb.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module two_wire_shift_serial_unit_tb;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_s;
  logic        core_clk, arst_n, psel, penable, pwrite, timer_match, err;
  logic [7:0]  paddr, rx;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, scl_oe, sda_oe, dout, start_irq, ovf_irq;
  logic        sck, din, sda, scl_out, sda_o, ovf_chain;
  int          err_total, num_checks, cyc, n_wrap;
  row_s        rows [11];

  // Open-drain lines
  wire scl_line = sck & ~scl_oe;
  wire sda_line = sda & ~sda_oe;

  two_wire_shift_serial_unit i_dut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .shift_clock_pin_in(scl_line),
    .shift_clock_pin_out(scl_out), .shift_clock_pin_oe(scl_oe), .sda_in(sda_line),
    .sda_out(sda_o), .sda_oe(sda_oe), .serial_in_pin(din), .data_out_pin(dout),
    .timer_match(timer_match), .counter_ovf_to_timer(ovf_chain), .start_irq(start_irq),
    .ovf_irq(ovf_irq));
  serial_bus_partner i_partner (.core_clk(core_clk), .scl_line(scl_line), .dout(dout),
    .sck(sck), .din(din), .sda(sda));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang limit
  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  // Count chain pulses to the companion timer
  always @(posedge core_clk) begin
    if (ovf_chain === 1'b1)
      n_wrap++;
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic summarize();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////////
  // Register table cases, then hand-written cases
  initial begin
    {arst_n, psel, penable, pwrite, timer_match, paddr, pwdata} = '0;
    rows = '{'{0, 8'h00, 0, 0, 0}, '{0, 8'h04, 0, 0, 0}, '{0, 8'h08, 0, 0, 0},
      '{1, 8'h00, 8'h5a, 0, 0}, '{0, 8'h00, 0, 8'h5a, 0}, '{1, 8'h08, 8'h14, 0, 0},
      '{0, 8'h08, 0, 8'h14, 0}, '{1, 8'h04, 8'h07, 0, 0}, '{0, 8'h04, 0, 8'h07, 0},
      '{0, 8'h0c, 0, 0, 1}, '{1, 8'h10, 8'hff, 0, 1}};
    repeat (20) @(posedge core_clk);
    chk({pready, pslverr, sda_oe, scl_oe, start_irq, ovf_irq, ovf_chain, scl_out, sda_o}, 0);
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      chk(rd, rows[i].x);
      chk(err, rows[i].e);
    end
    // Software strobe at counter F
    apb(1, 8'h00, 8'h81);
    apb(1, 8'h04, 8'h0f);
    apb(1, 8'h08, 8'h40);
    apb(1, 8'h08, 8'h41);
    apb(0, 8'h00, 0);
    chk(rd, 8'h03);
    apb(0, 8'h04, 0);
    chk(rd, 8'h40);
    chk(ovf_irq, 1'b1);
    apb(1, 8'h04, 8'h40);
    // Timer match source
    apb(1, 8'h08, 8'h04);
    timer_match <= 1'b1;
    @(posedge core_clk);
    timer_match <= 1'b0;
    apb(0, 8'h00, 0);
    chk(rd, 8'h07);
    apb(0, 8'h04, 0);
    chk(rd, 8'h01);
    // Pin edge at counter F, both edges counted
    apb(1, 8'h08, 8'h48);
    apb(1, 8'h04, 8'h0f);
    i_partner.edge_to(1'b0);
    repeat (2) @(posedge core_clk);
    chk(ovf_irq, 1'b1);
    i_partner.edge_to(1'b1);
    apb(0, 8'h04, 0);
    chk(rd, 8'h41);
    // Three-wire byte, falling edge shift
    apb(1, 8'h08, 8'h1c);
    apb(1, 8'h00, 8'ha5);
    apb(1, 8'h04, 8'h40);
    i_partner.send_byte(8'hc3, rx);
    chk(rx, 8'ha5);
    apb(0, 8'h00, 0);
    chk(rd, 8'hc3);
    apb(0, 8'h04, 0);
    chk(rd, 8'h40);
    // Start pattern ignored outside two-wire mode
    apb(1, 8'h04, 8'h40);
    apb(1, 8'h08, 8'h00);
    i_partner.sda_to(1'b0);
    apb(0, 8'h04, 0);
    chk(rd, 8'h00);
    i_partner.sda_to(1'b1);
    // Two-wire start, SCL hold until flag cleared, then hold on overflow
    apb(1, 8'h08, 8'hbc);
    i_partner.sda_to(1'b0);
    chk({start_irq, scl_oe}, 2'h3);
    apb(1, 8'h04, 8'h8f);
    repeat (2) @(posedge core_clk);
    chk({start_irq, scl_oe}, 2'h0);
    repeat (4) @(posedge core_clk);
    chk(scl_oe, 1'b1);
    apb(1, 8'h04, 8'h40);
    i_partner.sda_to(1'b1);
    chk(scl_oe, 1'b0);
    chk(n_wrap, 4);
    // Reset in mid-run returns registers to reset values
    arst_n <= 1'b0;
    @(posedge core_clk);
    chk({sda_oe, scl_oe, start_irq, ovf_irq, ovf_chain}, 0);
    arst_n <= 1'b1;
    apb(0, 8'h00, 0);
    chk(rd, 8'h00);
    apb(0, 8'h08, 0);
    chk(rd, 8'h00);
    summarize();
  end
endmodule : two_wire_shift_serial_unit_tb
